// ### rtl/tpc_pkg.sv
// Shared constants and types for the transmit phase compensation buffer.
package tpc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int TPC_MAX_WIDTH = 20;
    localparam int TPC_FIFO_DEPTH = 4;
    localparam int TPC_LEVEL_BITS = 3;

    // ------------------------------------------------------------------
    // Timing, in low-speed parallel clock ticks, and the priming fill level in words
    // ------------------------------------------------------------------
    localparam int TPC_LAT_MIN_TICKS = 2;
    localparam int TPC_LAT_MAX_TICKS = 3;
    localparam int TPC_REG_LAT_TICKS = 1;
    localparam logic [TPC_LEVEL_BITS-1:0] TPC_PRIME_LEVEL = 3'h2;

    // ------------------------------------------------------------------
    // Parallel clock divider: core clock cycles per parallel tick
    // ------------------------------------------------------------------
    localparam int TPC_PCLK_DIV = 4;
    localparam logic [7:0] TPC_PCLK_DIV_RST = 8'h00;

    // ------------------------------------------------------------------
    // Fabric-side width selection
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TPC_W8 = 2'h0,
        TPC_W10 = 2'h1,
        TPC_W16 = 2'h2,
        TPC_W20 = 2'h3
    } tpc_width_type;

    // ------------------------------------------------------------------
    // Control states, Gray coded along idle, prime, run; registered apart
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TPC_ST_IDLE = 2'h0,
        TPC_ST_PRIME = 2'h1,
        TPC_ST_RUN = 2'h3,
        TPC_ST_REG = 2'h2
    } tpc_state_type;

    // ------------------------------------------------------------------
    // One transmit word as it travels the path
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [TPC_MAX_WIDTH-1:0] data;
        logic valid;
    } tpc_word_type;

    // Status toward the coding sublayer and user logic.
    typedef struct packed {
        logic overflow;
        logic underflow;
        logic running;
        logic [TPC_LEVEL_BITS-1:0] level;
    } tpc_status_type;

endpackage

// ### rtl/tpc_fifo.sv
// Small synchronous FIFO with registered read data, used as the phase buffer.
`timescale 1ns/1ns
module tpc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8,
    parameter int LEVEL_BITS = 4
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_flush,
    // Fill side
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    // Drain side
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data,
    output logic o_rd_strobe,
    // Occupancy
    output logic [LEVEL_BITS-1:0] o_level
);

    localparam int PTR_BITS = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_BITS:0] wr_ptr_q;
    logic [PTR_BITS:0] rd_ptr_q;
    logic [PTR_BITS:0] used;
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign used = wr_ptr_q - rd_ptr_q;
    assign full = (used == (PTR_BITS+1)'(DEPTH));
    assign empty = (used == '0);
    assign o_wr_ready = !full;
    assign o_rd_valid = !empty;
    assign push = i_wr_valid && !full;
    assign pop = i_rd_ready && !empty;
    assign o_level = LEVEL_BITS'(used);

    // ------------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (i_flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // Storage has no reset so that it maps onto plain flops or LUT memory.
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q[PTR_BITS-1:0]] <= i_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // Registered read port
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data <= '0;
            o_rd_strobe <= 1'b0;
        end else begin
            o_rd_strobe <= pop && !i_flush;
            if (pop) begin
                o_rd_data <= mem_q[rd_ptr_q[PTR_BITS-1:0]];
            end
        end
    end

endmodule

// ### rtl/tpc_phase_buffer.sv
// Transmit phase compensation buffer between fabric words and the coding sublayer.
`timescale 1ns/1ns

// Summary of operation
// - Words written on fabric ticks leave in the same order on parallel ticks, absorbing phase.
// - The buffer storage holds exactly four words, each of the full 20-bit width whatever width is configured.
// - In normal mode a written word reaches the read side two to three parallel ticks later.
// - In deterministic latency mode the buffer is one register adding one parallel tick.
// - The fabric word width is selectable as 8, 10, 16 or 20 bits; fabric supplies that width.
// - Direct fabric words and PIPE-path words are buffered in exactly the same way.
// - Buffered words go on to the rest of the coding sublayer and then the serial stage.
module tpc_phase_buffer
    import tpc_pkg::*;
#(
    parameter int PCLK_DIV = tpc_pkg::TPC_PCLK_DIV,
    parameter int DEPTH = tpc_pkg::TPC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Configuration
    input wire tpc_pkg::tpc_width_type i_width_sel,
    input wire logic i_det_lat_mode,
    input wire logic i_pipe_sel,
    // Fabric side, one word per fabric tick
    input wire logic i_fab_tick,
    input wire tpc_pkg::tpc_word_type i_fab_word,
    input wire tpc_pkg::tpc_word_type i_pipe_word,
    output logic o_fab_ready,
    // Coding sublayer side
    output logic o_pclk_tick,
    output tpc_pkg::tpc_word_type o_pcs_word,
    // Status
    output tpc_pkg::tpc_status_type o_status
);

    import tpc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    tpc_state_type state_q;
    tpc_state_type state_d;
    logic [7:0] div_cnt_q;
    logic pclk_tick;
    logic det_lat_q;
    logic [1:0] width_q;
    logic mode_change;
    logic [TPC_MAX_WIDTH-1:0] width_mask;
    tpc_word_type src_word;
    logic [TPC_MAX_WIDTH-1:0] src_data;
    logic fifo_wr_valid;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    logic fifo_flush;
    logic [TPC_MAX_WIDTH-1:0] fifo_rd_data;
    logic fifo_rd_strobe;
    logic [TPC_LEVEL_BITS-1:0] fifo_level;
    logic [TPC_MAX_WIDTH-1:0] out_data_q;
    logic out_valid_q;
    logic overflow_q;
    logic underflow_q;

    // ------------------------------------------------------------------
    // Parallel clock enable
    // ------------------------------------------------------------------
    // The low-speed parallel clock is one enable pulse every PCLK_DIV core
    // cycles; the fabric tick arrives at the same rate but any phase.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_cnt_q <= TPC_PCLK_DIV_RST;
        end else if (div_cnt_q == 8'(PCLK_DIV - 1)) begin
            div_cnt_q <= TPC_PCLK_DIV_RST;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    assign pclk_tick = (div_cnt_q == 8'(PCLK_DIV - 1));
    assign o_pclk_tick = pclk_tick;

    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    // A change of mode or width restarts the buffer, since words of the
    // old shape left inside would come out with the wrong latency.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            det_lat_q <= 1'b0;
            width_q <= 2'h0;
        end else begin
            det_lat_q <= i_det_lat_mode;
            width_q <= i_width_sel;
        end
    end

    assign mode_change = (det_lat_q != i_det_lat_mode) || (width_q != i_width_sel);

    // ------------------------------------------------------------------
    // Source selection and width masking
    // ------------------------------------------------------------------
    always_comb begin
        src_word = i_pipe_sel ? i_pipe_word : i_fab_word;
    end

    always_comb begin
        case (i_width_sel)
            TPC_W8: width_mask = 20'h000ff;
            TPC_W10: width_mask = 20'h003ff;
            TPC_W16: width_mask = 20'h0ffff;
            TPC_W20: width_mask = 20'hfffff;
            default: width_mask = 20'hfffff;
        endcase
    end

    // Bits above the selected width are forced low so that stale lanes of a
    // wider earlier setting never reach the encoder.
    assign src_data = src_word.data & width_mask;

    // ------------------------------------------------------------------
    // Control state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            TPC_ST_IDLE: begin
                if (!mode_change) begin
                    state_d = i_det_lat_mode ? TPC_ST_REG : TPC_ST_PRIME;
                end
            end
            TPC_ST_PRIME: begin
                if (mode_change) begin
                    state_d = TPC_ST_IDLE;
                end else if (pclk_tick && fifo_level >= TPC_PRIME_LEVEL) begin
                    state_d = TPC_ST_RUN;
                end
            end
            TPC_ST_RUN: begin
                if (mode_change) begin
                    state_d = TPC_ST_IDLE;
                end else if (pclk_tick && !fifo_rd_valid) begin
                    state_d = TPC_ST_PRIME;
                end
            end
            TPC_ST_REG: begin
                if (mode_change) begin
                    state_d = TPC_ST_IDLE;
                end
            end
            default: begin
                state_d = TPC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= TPC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Phase buffer
    // ------------------------------------------------------------------
    // Writes follow the fabric tick, reads follow the parallel tick; the
    // two-word priming level sets the steady fill that gives the latency.
    assign fifo_flush = (state_q == TPC_ST_IDLE) || (state_q == TPC_ST_REG);
    assign fifo_wr_valid = i_fab_tick && src_word.valid
                           && (state_q == TPC_ST_PRIME || state_q == TPC_ST_RUN);
    assign fifo_rd_ready = pclk_tick && (state_q == TPC_ST_RUN);

    tpc_fifo #(
        .WIDTH(TPC_MAX_WIDTH),
        .DEPTH(DEPTH),
        .LEVEL_BITS(TPC_LEVEL_BITS)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_flush(fifo_flush),
        .i_wr_valid(fifo_wr_valid),
        .o_wr_ready(fifo_wr_ready),
        .i_wr_data(src_data),
        .o_rd_valid(fifo_rd_valid),
        .i_rd_ready(fifo_rd_ready),
        .o_rd_data(fifo_rd_data),
        .o_rd_strobe(fifo_rd_strobe),
        .o_level(fifo_level)
    );

    // Back-pressure reaches the fabric; with locked rates it drops only in the idle state.
    assign o_fab_ready = fifo_flush ? (state_q == TPC_ST_REG) : fifo_wr_ready;

    // ------------------------------------------------------------------
    // Output register toward the coding sublayer
    // ------------------------------------------------------------------
    // In registered mode the word present at a parallel tick is taken
    // straight into this register, so it leaves one tick later.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_data_q <= '0;
            out_valid_q <= 1'b0;
        end else if (state_q == TPC_ST_REG) begin
            if (pclk_tick) begin
                out_data_q <= src_data;
                out_valid_q <= src_word.valid;
            end
        end else if (fifo_rd_strobe) begin
            out_data_q <= fifo_rd_data;
            out_valid_q <= 1'b1;
        end else if (pclk_tick && state_q != TPC_ST_RUN) begin
            out_valid_q <= 1'b0;
        end
    end

    assign o_pcs_word.data = out_data_q;
    assign o_pcs_word.valid = out_valid_q;

    // ------------------------------------------------------------------
    // Error flags
    // ------------------------------------------------------------------
    // A rate mismatch shows up as a write into a full buffer or a read
    // from an empty one. The flags hold until the buffer is restarted.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            overflow_q <= 1'b0;
        end else if (fifo_wr_valid && !fifo_wr_ready) begin
            overflow_q <= 1'b1;
        end else if (state_q == TPC_ST_IDLE) begin
            overflow_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            underflow_q <= 1'b0;
        end else if (state_q == TPC_ST_RUN && pclk_tick && !fifo_rd_valid) begin
            underflow_q <= 1'b1;
        end else if (state_q == TPC_ST_IDLE) begin
            underflow_q <= 1'b0;
        end
    end

    assign o_status.overflow = overflow_q;
    assign o_status.underflow = underflow_q;
    assign o_status.running = (state_q == TPC_ST_RUN) || (state_q == TPC_ST_REG);
    assign o_status.level = fifo_level;

endmodule

// ### testbench/tpc_phase_buffer_assertions.sv
// Port-level assertions for the transmit phase compensation buffer.
`timescale 1ns/1ns
module tpc_phase_buffer_checker
    import tpc_pkg::*;
#(
    parameter int PCLK_DIV = 4,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Configuration
    input wire tpc_pkg::tpc_width_type i_width_sel,
    input wire logic i_det_lat_mode,
    input wire logic i_pipe_sel,
    // Fabric side
    input wire logic i_fab_tick,
    input wire tpc_pkg::tpc_word_type i_fab_word,
    input wire tpc_pkg::tpc_word_type i_pipe_word,
    input wire logic o_fab_ready,
    // Coding side
    input wire logic o_pclk_tick,
    input wire tpc_pkg::tpc_word_type o_pcs_word,
    input wire tpc_pkg::tpc_status_type o_status
);
    // ------
    // Helpers
    // ------
    tpc_word_type src, srcm;
    logic [19:0] mask;
    logic [2:0] cfg_q;
    logic [4:0] age_q;
    logic [7:0] gap_q;
    logic seen_q, steady;
    assign src = i_pipe_sel ? i_pipe_word : i_fab_word;
    assign mask = (i_width_sel == TPC_W8) ? 20'h000ff : (i_width_sel == TPC_W10) ? 20'h003ff
        : (i_width_sel == TPC_W16) ? 20'h0ffff : 20'hfffff;
    assign srcm = {src.data & mask, src.valid};
    // A mode change restarts the buffer, so most checks wait until it has settled.
    assign steady = age_q >= 5'h8 && cfg_q == {i_width_sel, i_det_lat_mode};
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_q <= 3'h0;
            age_q <= 5'h0;
        end else begin
            cfg_q <= {i_width_sel, i_det_lat_mode};
            if (cfg_q != {i_width_sel, i_det_lat_mode}) age_q <= 5'h0;
            else if (age_q != 5'h1f) age_q <= age_q + 5'h1;
        end
    end
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gap_q <= 8'h0;
            seen_q <= 1'b0;
        end else if (o_pclk_tick) begin
            gap_q <= 8'h1;
            seen_q <= 1'b1;
        end else if (gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h1;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_fab_write;
        i_fab_tick && src.valid && o_fab_ready;
    endsequence
    sequence s_full_write;
        steady && i_fab_tick && src.valid && o_status.level == 3'(DEPTH);
    endsequence
    // ------
    // Assertions
    // ------
    a_level_in_depth: assert property (o_status.level <= 3'(DEPTH))
        else $error("buffer level above its depth");
    a_pclk_period: assert property (o_pclk_tick && seen_q |-> gap_q == 8'(PCLK_DIV))
        else $error("parallel tick spacing wrong");
    a_full_refused: assert property (s_full_write |-> !o_fab_ready ##1 o_status.overflow)
        else $error("write into full buffer not refused");
    a_ovf_sticky: assert property (steady && o_status.overflow |=> o_status.overflow)
        else $error("overflow flag dropped without restart");
    a_reg_one_tick: assert property (steady && i_det_lat_mode && o_pclk_tick |=>
        o_pcs_word == $past(srcm)) else $error("registered mode word not one tick later");
    a_out_hold: assert property (steady && !o_pclk_tick && !$past(o_pclk_tick) |=>
        $stable(o_pcs_word)) else $error("output word changed between ticks");
    a_width_mask: assert property (steady && age_q == 5'h1f |->
        (o_pcs_word.data & ~mask) == 20'h0) else $error("bits above width not zero");
    a_write_count: assert property ((steady && !i_det_lat_mode && !o_pclk_tick) ##0 s_fab_write
        |=> o_status.level == $past(o_status.level) + 3'h1) else $error("write not stored");
endmodule

bind tpc_phase_buffer tpc_phase_buffer_checker #(.PCLK_DIV(PCLK_DIV), .DEPTH(DEPTH)) u_chk (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_width_sel(i_width_sel),
    .i_det_lat_mode(i_det_lat_mode), .i_pipe_sel(i_pipe_sel), .i_fab_tick(i_fab_tick),
    .i_fab_word(i_fab_word), .i_pipe_word(i_pipe_word), .o_fab_ready(o_fab_ready),
    .o_pclk_tick(o_pclk_tick), .o_pcs_word(o_pcs_word), .o_status(o_status));

// ### testbench/tpc_fabric_model.sv
// Model of the user logic that feeds transmit words from the fabric.
`timescale 1ns/1ns
module tpc_fabric_model
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Bench control
    input wire logic i_run,
    input wire logic i_pipe_sel,
    input wire logic [2:0] i_period,
    input wire logic [1:0] i_phase,
    // Words toward the buffer
    output logic o_fab_tick,
    output tpc_pkg::tpc_word_type o_fab_word,
    output tpc_pkg::tpc_word_type o_pipe_word
);
    logic [2:0] cnt_q;
    logic [7:0] seq_q;
    logic [19:0] word_q, junk;
    logic hit;
    assign hit = i_run && cnt_q == {1'b0, i_phase};
    // The unused source churns every cycle so a wrong selection cannot pass.
    assign junk = ~word_q ^ {17'h0, cnt_q};
    assign o_fab_word = i_pipe_sel ? {junk, 1'b1} : {word_q, 1'b1};
    assign o_pipe_word = i_pipe_sel ? {word_q, 1'b1} : {junk, 1'b1};
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 3'h0;
            seq_q <= 8'h00;
            word_q <= 20'h0;
            o_fab_tick <= 1'b0;
        end else begin
            cnt_q <= (cnt_q + 3'h1 >= i_period) ? 3'h0 : cnt_q + 3'h1;
            o_fab_tick <= hit;
            if (hit) begin
                seq_q <= seq_q + 8'h01;
                word_q <= {12'ha5c, seq_q};
            end
        end
    end
endmodule

// ### testbench/tb_tpc_phase_buffer.sv
// Self-checking bench for the transmit phase compensation buffer.
`timescale 1ns/1ns
module tb_tpc_phase_buffer;
    import tpc_pkg::*;
    logic core_clk, sys_rst, det_mode, pipe_sel, run, fab_ready, pclk_tick, fab_tick, mon_en, prev_t;
    tpc_width_type width;
    logic [2:0] period, lvl_max;
    logic [1:0] phase;
    tpc_word_type fab_word, pipe_word, pcs_word, src;
    tpc_status_type status;
    logic [19:0] last_data, prev_w;
    logic [19:0] exp_d[$];
    int exp_t[$];
    int n_errors, num_checks, n_words, tcnt, gap;
    assign src = pipe_sel ? pipe_word : fab_word;
    tpc_fabric_model u_fab (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_run(run),
        .i_pipe_sel(pipe_sel), .i_period(period), .i_phase(phase), .o_fab_tick(fab_tick),
        .o_fab_word(fab_word), .o_pipe_word(pipe_word));
    tpc_phase_buffer #(.PCLK_DIV(TPC_PCLK_DIV), .DEPTH(TPC_FIFO_DEPTH)) u_dut (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_width_sel(width),
        .i_det_lat_mode(det_mode), .i_pipe_sel(pipe_sel), .i_fab_tick(fab_tick),
        .i_fab_word(fab_word), .i_pipe_word(pipe_word), .o_fab_ready(fab_ready),
        .o_pclk_tick(pclk_tick), .o_pcs_word(pcs_word), .o_status(status));
    function automatic logic [19:0] mask_of(input tpc_width_type w);
        case (w)
            TPC_W8: return 20'h000ff;
            TPC_W10: return 20'h003ff;
            TPC_W16: return 20'h0ffff;
            default: return 20'hfffff;
        endcase
    endfunction
    task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({19'h0, got}, {19'h0, exp});
    endtask
    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Restart the buffer with a new mode; the fabric is stopped across the change.
    task automatic cfg(input tpc_width_type w, input logic det, input logic ps,
            input logic mon, input logic [1:0] ph);
        @(negedge core_clk);
        mon_en = 1'b0;
        @(posedge core_clk);
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        width <= (w == TPC_W20) ? TPC_W8 : TPC_W20;
        phase <= ph;
        repeat (3) @(posedge core_clk);
        width <= w;
        det_mode <= det;
        pipe_sel <= ps;
        repeat (4) @(negedge core_clk);
        exp_d.delete();
        exp_t.delete();
        n_words = 0;
        lvl_max = 3'h0;
        prev_t = 1'b0;
        // Inverted so that a first word equal to the stale output still counts as new.
        last_data = ~pcs_word.data;
        mon_en = mon;
        @(posedge core_clk);
        run <= 1'b1;
    endtask
    // Normal mode: order, value and latency of every word are judged by the monitor.
    always @(posedge core_clk) begin
        if (status.level > lvl_max) lvl_max = status.level;
        if (mon_en && !det_mode) begin
            if (pcs_word.valid === 1'b1 && pcs_word.data !== last_data) begin
                last_data = pcs_word.data;
                n_words++;
                if (exp_d.size() == 0) chk_bit(1'b0, 1'b1);
                else begin
                    chk_val(pcs_word.data, exp_d.pop_front());
                    gap = tcnt - exp_t.pop_front();
                    chk_bit(gap >= TPC_LAT_MIN_TICKS && gap <= TPC_LAT_MAX_TICKS, 1'b1);
                end
            end
            if (pclk_tick === 1'b1) tcnt++;
            if ((fab_tick && src.valid && fab_ready) === 1'b1) begin
                exp_d.push_back(src.data & mask_of(width));
                exp_t.push_back(tcnt);
            end
        end
        if (mon_en && det_mode) begin
            if (prev_t) chk_val(pcs_word.data, prev_w);
            if (prev_t) chk_bit(pcs_word.valid, 1'b1);
            if (prev_t) n_words++;
            prev_t = (pclk_tick === 1'b1);
            prev_w = src.data & mask_of(width);
        end
    end
    task automatic t_stream(input tpc_width_type w, input logic [1:0] ph, input logic ps);
        cfg(w, 1'b0, ps, 1'b1, ph);
        repeat (80) @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(n_words >= 12, 1'b1);
        chk_bit(status.underflow, 1'b0);
        chk_bit(status.running, 1'b1);
        $display("stream width %0d phase %0d pipe %0d done", w, ph, ps);
    endtask
    task automatic t_det_mode;
        cfg(TPC_W16, 1'b1, 1'b1, 1'b1, 2'h1);
        repeat (80) @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(n_words >= 16, 1'b1);
        chk_bit(status.running, 1'b1);
        $display("registered mode done");
    endtask
    task automatic t_overflow;
        cfg(TPC_W10, 1'b0, 1'b0, 1'b0, 2'h0);
        period <= 3'h2;
        repeat (60) @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(status.overflow, 1'b1);
        chk_val({17'h0, lvl_max}, 20'(TPC_FIFO_DEPTH));
        period <= 3'h4;
        cfg(TPC_W8, 1'b0, 1'b0, 1'b1, 2'h3);
        @(negedge core_clk);
        chk_bit(status.overflow, 1'b0);
        repeat (40) @(posedge core_clk);
        chk_bit(n_words >= 5, 1'b1);
        $display("overflow done");
    endtask
    task automatic t_underflow;
        cfg(TPC_W20, 1'b0, 1'b0, 1'b1, 2'h2);
        repeat (40) @(posedge core_clk);
        run <= 1'b0;
        repeat (24) @(posedge core_clk);
        @(negedge core_clk);
        chk_bit(status.underflow, 1'b1);
        chk_bit(exp_d.size() == 0, 1'b1);
        chk_bit(status.running, 1'b0);
        chk_bit(pcs_word.valid, 1'b0);
        $display("underflow done");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        n_errors++;
        $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        stop_test;
    end
    initial begin
        sys_rst = 1'b1;
        width = TPC_W20;
        det_mode = 1'b0;
        pipe_sel = 1'b0;
        run = 1'b0;
        period = 3'h4;
        phase = 2'h0;
        mon_en = 1'b0;
        prev_t = 1'b0;
        lvl_max = 3'h0;
        last_data = 20'h0;
        prev_w = 20'h0;
        repeat (15) @(posedge core_clk);
        chk_bit(fab_ready, 1'b0);
        chk_val(pcs_word.data, 20'h0);
        chk_val({14'h0, status}, 20'h0);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) t_stream(tpc_width_type'(i), 2'(i), i[0]);
        t_det_mode;
        t_overflow;
        t_underflow;
        stop_test;
    end
endmodule
